// ---- rtl/lmc_pkg.sv ----
/*
  Shared constants, carrier types and the CRC step of the logger memory
  command unit. Assumes a 50 MHz system clock and LSB-first serial bytes.
*/
package lmc_pkg;

  // ----------------------------------------------------------------
  // function command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WRITE_SP = 8'h0F;
  localparam logic [7:0] CMD_READ_SP = 8'hAA;
  localparam logic [7:0] CMD_COPY_SP = 8'h55;
  localparam logic [7:0] CMD_READ_MEM = 8'hF0;
  localparam logic [7:0] CMD_READ_MEM_CRC = 8'hA5;
  localparam logic [7:0] CMD_CLEAR_MEM = 8'h3C;
  localparam logic [7:0] CMD_CONVERT = 8'h44;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int COPY_BYTE_NS = 2000;
  localparam int COPY_BYTE_CYCLES = (COPY_BYTE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLEAR_TIME_US = 500;
  localparam int CLEAR_CYCLES = (CLEAR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] LOAD_WAIT = 2'h2;

  // ----------------------------------------------------------------
  // addresses, fields and counts
  // ----------------------------------------------------------------
  localparam logic [15:0] PROT_ADDR_LO = 16'h0200;
  localparam logic [15:0] PROT_ADDR_HI = 16'h0213;
  localparam logic [15:0] SAMPLE_RATE_ADDR = 16'h020D;
  localparam int SP_BYTES = 32;
  localparam int OFF_W = 5;
  localparam logic [OFF_W-1:0] SP_LAST_OFF = 5'h1F;
  localparam logic [3:0] BIT_LAST_BYTE = 4'h7;
  localparam logic [3:0] BIT_LAST_CRC = 4'hF;
  localparam logic [1:0] HDR_BYTES = 2'h3;
  localparam logic [15:0] CRC_POLY_REFL = 16'hA001;
  localparam logic [15:0] CRC_CLEAR = 16'h0000;
  localparam logic ES_ZERO_BIT = 1'b0;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] data;
  } lmc_mem_wr_t;

  // gray codes along the usual command path
  typedef enum logic [3:0] {
    ST_CMD = 4'h0,
    ST_ADDR = 4'h1,
    ST_WDATA = 4'h3,
    ST_WCRC = 4'h2,
    ST_AUTH = 4'h6,
    ST_COPY = 4'h7,
    ST_PATTERN = 4'h5,
    ST_RDATA = 4'h4,
    ST_RCRC = 4'hC,
    ST_ONES = 4'hD,
    ST_IDLE = 4'hF
  } lmc_state_t;

  // one bit of the reflected CRC16 generator
  function automatic logic [15:0] lmc_crc16_step(input logic [15:0] crc, input logic din);
    lmc_crc16_step = (crc >> 1) ^ ((crc[0] ^ din) ? CRC_POLY_REFL : CRC_CLEAR);
  endfunction : lmc_crc16_step

endpackage : lmc_pkg

// ---- rtl/lmc_unit.sv ----
/*
  Memory and control function command unit of a logging slave, plus the
  write FIFO in front of the memory write port. Assumes slot timing, ROM
  commands and bus reset are handled upstream on the same clock, and that
  memory read data follows memRdAddr by one clock.
*/
//
// Function
// - address low first, data stored at offset
// - ending offset tracks bytes, partial sets flag
// - write CRC, inverted answer at offset 1Fh
// - mission protects register page 200h-213h
// - read scratchpad sends address, status, data
// - read to end, inverted CRC, ones
// - copy authorised by address and status
// - alternating pattern after copy completes
// - reset ignored during copy, 2us byte
// - copy beginning through ending offset
// - auth flag held until next write
// - copy into 200h-213h stops mission
// - read memory streams, zeros past end
// - CRC read: inverted CRC per page
// - first page CRC covers command, address
// - past end zeros with page CRCs
// - clear memory wipes mission areas only
// - clear needs enable, next command, 500us
// - convert only without mission, bus served
// - non-zero rate copy starts mission
// - start delay minutes, then stamp, log
// - status byte: auth, zero, partial, offset
// - start triggered by copy to 020Dh
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// write FIFO
// ------------------------------------------------------------------
module lmc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wrPtr_q;
  logic [AW-1:0] rdPtr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  // honest full and empty from the occupancy count
  assign inReady = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData = mem_q[rdPtr_q];
  assign push = ce & inValid & inReady;
  assign pop = ce & outValid & outReady;

  // storage, no reset needed for data words
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  // pointers and count
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wrPtr_q <= wrPtr_q + 1'b1;
      if (pop) rdPtr_q <= rdPtr_q + 1'b1;
      if (push && !pop) count_q <= count_q + 1'b1;
      else if (pop && !push) count_q <= count_q - 1'b1;
    end
  end
endmodule : lmc_fifo

// ------------------------------------------------------------------
// command unit
// ------------------------------------------------------------------
module lmc_unit import lmc_pkg::*; #(
  parameter logic [15:0] MEM_LAST_ADDR = 16'h0FFF,
  parameter int CLEAR_CYC = CLEAR_CYCLES,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic busResetPulse,
  input wire logic slotPulse,
  input wire logic slotBit,
  output logic txBit,
  output logic [15:0] memRdAddr,
  input wire logic [7:0] memRdData,
  output lmc_mem_wr_t memWr,
  output logic memWrValid,
  input wire logic memWrReady,
  input wire logic clearEnableSet,
  input wire logic missionInhibitBit,
  input wire logic minuteTick,
  input wire logic [15:0] startDelay,
  output logic clearEnableBit,
  output logic memoryClearedFlag,
  output logic missionActiveFlag,
  output logic memClearReq,
  output logic convStart,
  output logic stampReq,
  output logic loggingOn,
  output logic [7:0] sampleRate,
  output logic [7:0] statusByte
);
  localparam int CTW = $clog2(COPY_BYTE_CYCLES + 1);
  localparam int KTW = $clog2(CLEAR_CYC + 1);

  lmc_state_t state_q;
  logic [3:0] bitCnt_q;
  logic [7:0] rxSh_q;
  logic [15:0] txSh_q;
  logic [15:0] crc_q;
  logic [7:0] cmd_q;
  logic [15:0] ta_q;
  logic [OFF_W-1:0] endOff_q;
  logic [OFF_W-1:0] wrOff_q;
  logic [OFF_W-1:0] copyOff_q;
  logic [5:0] rdOff_q;
  logic pf_q;
  logic aa_q;
  logic authOk_q;
  logic [1:0] byteCnt_q;
  logic [1:0] loadWait_q;
  logic blockEnd_q;
  logic pastEnd_q;
  logic patt_q;
  logic [15:0] memAddr_q;
  logic [CTW-1:0] copyTmr_q;
  logic [7:0] sp_q [SP_BYTES];
  logic clearBusy_q;
  logic [KTW-1:0] clearTmr_q;
  logic [15:0] delayCnt_q;

  logic slotEv;
  logic rstEv;
  logic isRx;
  logic isTx;
  logic curBit;
  logic [15:0] crcNext;
  logic [7:0] rxByte;
  logic rxDone;
  logic txDone;
  logic [7:0] rdByte;
  logic [15:0] copyAddr;
  logic [7:0] copyData;
  logic inProt;
  logic copyFire;
  logic fifoInReady;
  logic startMission;
  logic stopMission;
  logic cmdDone;
  logic clearDone;

  // ----------------------------------------------------------------
  // slot decode
  // ----------------------------------------------------------------
  assign slotEv = ce & slotPulse;
  assign rstEv = ce & busResetPulse & (state_q != ST_COPY);
  assign isRx = (state_q == ST_CMD) | (state_q == ST_ADDR) | (state_q == ST_WDATA)
              | (state_q == ST_AUTH);
  assign isTx = (state_q == ST_WCRC) | (state_q == ST_RDATA) | (state_q == ST_RCRC);
  assign curBit = isRx ? slotBit : txSh_q[0];
  assign crcNext = lmc_crc16_step(crc_q, curBit);
  assign rxByte = {slotBit, rxSh_q[7:1]};
  assign rxDone = slotEv & isRx & (bitCnt_q == BIT_LAST_BYTE);
  assign txDone = slotEv & isTx
                & (bitCnt_q == ((state_q == ST_RDATA) ? BIT_LAST_BYTE : BIT_LAST_CRC));
  assign cmdDone = rxDone & (state_q == ST_CMD);
  assign statusByte = {aa_q, ES_ZERO_BIT, pf_q, endOff_q};
  assign memRdAddr = memAddr_q;

  // released bus reads as one; idle and unknown command stay released
  always_comb begin
    unique case (state_q)
      ST_WCRC, ST_RDATA, ST_RCRC: txBit = txSh_q[0];
      ST_PATTERN: txBit = patt_q;
      default: txBit = 1'b1;
    endcase
  end

  // next outgoing data byte for the read commands
  always_comb begin
    if (cmd_q == CMD_READ_SP) begin
      unique case (byteCnt_q)
        2'h0: rdByte = ta_q[7:0];
        2'h1: rdByte = ta_q[15:8];
        2'h2: rdByte = statusByte;
        default: rdByte = sp_q[rdOff_q[OFF_W-1:0]];
      endcase
    end else begin
      rdByte = pastEnd_q ? 8'h00 : memRdData;
    end
  end

  // ----------------------------------------------------------------
  // copy engine terms
  // ----------------------------------------------------------------
  assign copyAddr = {ta_q[15:OFF_W], copyOff_q};
  assign copyData = sp_q[copyOff_q];
  assign inProt = (copyAddr >= PROT_ADDR_LO) && (copyAddr <= PROT_ADDR_HI);
  // a full FIFO stalls the copy rather than dropping a byte
  assign copyFire = ce & (state_q == ST_COPY) & (copyTmr_q == '0) & fifoInReady;
  assign stopMission = copyFire & missionActiveFlag & inProt;
  assign startMission = copyFire & ~missionActiveFlag & memoryClearedFlag & ~missionInhibitBit
                      & (copyAddr == SAMPLE_RATE_ADDR) & (copyData != 8'h00);

  lmc_fifo #(
    .WIDTH($bits(lmc_mem_wr_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .inData({copyAddr, copyData}),
    .inValid((state_q == ST_COPY) && (copyTmr_q == '0) && !(missionActiveFlag && inProt)),
    .inReady(fifoInReady),
    .outData(memWr),
    .outValid(memWrValid),
    .outReady(memWrReady)
  );

  // ----------------------------------------------------------------
  // command sequencer and bit engine
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      bitCnt_q <= '0;
      rxSh_q <= '0;
      txSh_q <= '0;
      crc_q <= CRC_CLEAR;
      cmd_q <= '0;
      ta_q <= '0;
      wrOff_q <= '0;
      copyOff_q <= '0;
      rdOff_q <= '0;
      byteCnt_q <= '0;
      loadWait_q <= '0;
      blockEnd_q <= 1'b0;
      pastEnd_q <= 1'b0;
      patt_q <= 1'b0;
      memAddr_q <= '0;
      copyTmr_q <= '0;
      authOk_q <= 1'b0;
    end else if (rstEv) begin
      state_q <= ST_CMD;
      bitCnt_q <= '0;
      crc_q <= CRC_CLEAR;
      loadWait_q <= '0;
    end else if (ce) begin
      // deferred byte load gives the memory a clock to answer
      if (loadWait_q != '0) begin
        loadWait_q <= loadWait_q - 1'b1;
        if (loadWait_q == 2'h1) begin
          txSh_q <= {8'h00, rdByte};
          if (cmd_q == CMD_READ_SP) begin
            blockEnd_q <= (byteCnt_q == HDR_BYTES) && (rdOff_q[OFF_W-1:0] == SP_LAST_OFF);
            if (byteCnt_q != HDR_BYTES) byteCnt_q <= byteCnt_q + 1'b1;
            else rdOff_q <= rdOff_q + 1'b1;
          end else begin
            blockEnd_q <= (cmd_q == CMD_READ_MEM_CRC)
                        && (memAddr_q[OFF_W-1:0] == SP_LAST_OFF);
            if (memAddr_q == MEM_LAST_ADDR) pastEnd_q <= 1'b1;
            memAddr_q <= memAddr_q + 1'b1;
          end
        end
      end
      if (slotEv && (isRx || isTx)) begin
        bitCnt_q <= bitCnt_q + 1'b1;
        crc_q <= crcNext;
        rxSh_q <= rxByte;
        if (isTx) txSh_q <= {1'b1, txSh_q[15:1]};
      end
      if (slotEv && state_q == ST_PATTERN) patt_q <= ~patt_q;
      if (rxDone || txDone) bitCnt_q <= '0;
      unique case (state_q)
        ST_CMD: if (rxDone) begin
          cmd_q <= rxByte;
          byteCnt_q <= '0;
          unique case (rxByte)
            CMD_WRITE_SP, CMD_READ_MEM, CMD_READ_MEM_CRC: state_q <= ST_ADDR;
            CMD_READ_SP: begin
              state_q <= ST_RDATA;
              rdOff_q <= {1'b0, ta_q[OFF_W-1:0]};
              loadWait_q <= LOAD_WAIT;
            end
            CMD_COPY_SP: begin
              state_q <= ST_AUTH;
              authOk_q <= 1'b1;
            end
            default: state_q <= ST_IDLE;
          endcase
        end
        ST_ADDR: if (rxDone) begin
          if (byteCnt_q == 2'h0) begin
            ta_q[7:0] <= rxByte;
            byteCnt_q <= 2'h1;
          end else begin
            ta_q[15:8] <= rxByte;
            byteCnt_q <= '0;
            if (cmd_q == CMD_WRITE_SP) begin
              state_q <= ST_WDATA;
              wrOff_q <= ta_q[OFF_W-1:0];
            end else begin
              state_q <= ST_RDATA;
              memAddr_q <= {rxByte, ta_q[7:0]};
              pastEnd_q <= 1'b0;
              loadWait_q <= LOAD_WAIT;
            end
          end
        end
        ST_WDATA: if (rxDone) begin
          if (wrOff_q == SP_LAST_OFF) begin
            state_q <= ST_WCRC;
            txSh_q <= ~crcNext;
          end else begin
            wrOff_q <= wrOff_q + 1'b1;
          end
        end
        ST_WCRC: if (txDone) state_q <= ST_ONES;
        ST_AUTH: if (rxDone) begin
          byteCnt_q <= byteCnt_q + 1'b1;
          unique case (byteCnt_q)
            2'h0: authOk_q <= authOk_q & (rxByte == ta_q[7:0]);
            2'h1: authOk_q <= authOk_q & (rxByte == ta_q[15:8]);
            default: begin
              if (authOk_q && rxByte == statusByte) begin
                state_q <= ST_COPY;
                copyOff_q <= ta_q[OFF_W-1:0];
                copyTmr_q <= CTW'(COPY_BYTE_CYCLES - 1);
              end else begin
                state_q <= ST_IDLE;
              end
            end
          endcase
        end
        ST_COPY: begin
          if (copyTmr_q != '0) begin
            copyTmr_q <= copyTmr_q - 1'b1;
          end else if (copyFire) begin
            if (copyOff_q == endOff_q) begin
              state_q <= ST_PATTERN;
              patt_q <= 1'b0;
            end else begin
              copyOff_q <= copyOff_q + 1'b1;
              copyTmr_q <= CTW'(COPY_BYTE_CYCLES - 1);
            end
          end
        end
        ST_RDATA: if (txDone) begin
          if (blockEnd_q) begin
            state_q <= ST_RCRC;
            txSh_q <= ~crcNext;
          end else begin
            loadWait_q <= LOAD_WAIT;
          end
        end
        ST_RCRC: if (txDone) begin
          if (cmd_q == CMD_READ_SP) begin
            state_q <= ST_ONES;
          end else begin
            state_q <= ST_RDATA;
            crc_q <= CRC_CLEAR;
            loadWait_q <= LOAD_WAIT;
          end
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // scratchpad storage and transfer status
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SP_BYTES; i++) sp_q[i] <= '0;
      endOff_q <= '0;
      pf_q <= 1'b0;
      aa_q <= 1'b0;
    end else if (ce) begin
      if (cmdDone && rxByte == CMD_WRITE_SP) begin
        aa_q <= 1'b0;
        pf_q <= 1'b0;
      end
      if (rxDone && state_q == ST_WDATA) begin
        sp_q[wrOff_q] <= rxByte;
        endOff_q <= wrOff_q;
      end
      // a write cut off mid byte drops the byte and flags it
      if (busResetPulse && state_q == ST_WDATA && bitCnt_q != '0) pf_q <= 1'b1;
      if (rxDone && state_q == ST_AUTH && byteCnt_q == 2'h2 && authOk_q
          && rxByte == statusByte) aa_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // clear memory and convert
  // ----------------------------------------------------------------
  assign clearDone = clearBusy_q && (clearTmr_q == '0);

  // the clear keeps running across bus resets once started
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      clearEnableBit <= 1'b0;
      clearBusy_q <= 1'b0;
      clearTmr_q <= '0;
      memClearReq <= 1'b0;
      convStart <= 1'b0;
    end else if (ce) begin
      memClearReq <= 1'b0;
      convStart <= 1'b0;
      if (clearBusy_q) clearTmr_q <= clearTmr_q - 1'b1;
      if (clearDone) clearBusy_q <= 1'b0;
      if (cmdDone && rxByte == CMD_CLEAR_MEM && clearEnableBit && !clearBusy_q) begin
        clearBusy_q <= 1'b1;
        clearTmr_q <= KTW'(CLEAR_CYC - 1);
        memClearReq <= 1'b1;
      end
      if (cmdDone && rxByte == CMD_CONVERT && !missionActiveFlag) convStart <= 1'b1;
      // set from the control register wins over a clear
      if (clearEnableSet) clearEnableBit <= 1'b1;
      else if ((cmdDone && rxByte != CMD_CLEAR_MEM) || clearDone) clearEnableBit <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // mission control
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      missionActiveFlag <= 1'b0;
      memoryClearedFlag <= 1'b0;
      sampleRate <= '0;
      delayCnt_q <= '0;
      loggingOn <= 1'b0;
      stampReq <= 1'b0;
    end else if (ce) begin
      stampReq <= 1'b0;
      if (clearDone) begin
        memoryClearedFlag <= 1'b1;
        sampleRate <= '0;
      end
      if (startMission) begin
        missionActiveFlag <= 1'b1;
        memoryClearedFlag <= 1'b0;
        sampleRate <= copyData;
        delayCnt_q <= startDelay;
        loggingOn <= 1'b0;
      end else if (stopMission) begin
        missionActiveFlag <= 1'b0;
        loggingOn <= 1'b0;
      end else if (missionActiveFlag && !loggingOn && minuteTick) begin
        // counted down, the next minute boundary stamps and logs
        if (delayCnt_q != '0) begin
          delayCnt_q <= delayCnt_q - 1'b1;
        end else begin
          stampReq <= 1'b1;
          loggingOn <= 1'b1;
        end
      end
    end
  end

endmodule : lmc_unit
`default_nettype wire

// ---- testbench/lmc_master.sv ----
/* Bus master model: reset pulses and time slots.
   Assumes txBit holds the device bit for the coming slot. */
`timescale 1ns/1ps
`default_nettype none
module lmc_master (
  input wire logic sys_clk,
  input wire logic txBit,
  output logic busResetPulse,
  output logic slotPulse,
  output logic slotBit
);
  initial begin
    busResetPulse = 1'b0;
    slotPulse = 1'b0;
    slotBit = 1'b1;
  end
  // reset pulse, then idle a few clocks
  task automatic busReset();
    @(negedge sys_clk);
    busResetPulse = 1'b1;
    @(negedge sys_clk);
    busResetPulse = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask : busReset
  // n slots lsb first; a read slot writes 1 and samples the device
  task automatic xfer(input int n, input logic [15:0] w, output logic [15:0] r);
    r = 16'hFFFF;
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      r[i] = txBit;
      slotPulse = 1'b1;
      slotBit = w[i];
      @(negedge sys_clk);
      slotPulse = 1'b0;
      slotBit = ~w[i]; // no stale bit between slots
      repeat (3) @(negedge sys_clk);
    end
  endtask : xfer
endmodule : lmc_master
`default_nettype wire

// ---- testbench/lmc_unit_sva.sv ----
/* Port checker for the command unit.
   Assumes one clock domain; bound below. */
`timescale 1ns/1ps
`default_nettype none
module lmc_unit_sva import lmc_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire lmc_mem_wr_t memWr,
  input wire logic memWrValid,
  input wire logic memWrReady,
  input wire logic clearEnableBit,
  input wire logic memoryClearedFlag,
  input wire logic missionActiveFlag,
  input wire logic memClearReq,
  input wire logic convStart,
  input wire logic stampReq,
  input wire logic loggingOn,
  input wire logic [7:0] sampleRate,
  input wire logic [7:0] statusByte
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----
  // checks
  // ----
  a_status_zero: assert property (statusByte[6] == ES_ZERO_BIT)
    else $error("status bit 6 set");
  a_clear_done: assert property ($rose(memoryClearedFlag) |-> !clearEnableBit)
    else $error("enable left after clear");
  a_clear_wipe: assert property ($rose(memoryClearedFlag) |-> sampleRate == 8'h00)
    else $error("rate kept by clear");
  a_clear_req: assert property (memClearReq |-> clearEnableBit)
    else $error("clear without enable");
  a_clear_slow: assert property (memClearReq && !memoryClearedFlag |=> !memoryClearedFlag [*8])
    else $error("clear ended too soon");
  a_conv_idle: assert property (convStart |-> !missionActiveFlag)
    else $error("convert during mission");
  a_mission_start: assert property ($rose(missionActiveFlag) |->
    $past(memoryClearedFlag) && !memoryClearedFlag && sampleRate != 8'h00)
    else $error("bad mission start");
  a_stamp_mission: assert property (stampReq |-> missionActiveFlag)
    else $error("stamp outside mission");
  a_log_mission: assert property ($rose(loggingOn) |-> missionActiveFlag)
    else $error("logging outside mission");
  a_rate_kept: assert property (missionActiveFlag && $past(missionActiveFlag) |->
    $stable(sampleRate))
    else $error("rate changed in mission");
  a_wr_hold: assert property (memWrValid && !memWrReady |=> memWrValid && $stable(memWr))
    else $error("write dropped while stalled");
  c_clear: cover property ($rose(memoryClearedFlag));
  c_mission: cover property ($rose(missionActiveFlag));
  c_stall: cover property (memWrValid && !memWrReady);
endmodule : lmc_unit_sva

bind lmc_unit lmc_unit_sva u_sva (.sys_clk, .rst, .memWr, .memWrValid, .memWrReady,
  .clearEnableBit, .memoryClearedFlag, .missionActiveFlag, .memClearReq, .convStart,
  .stampReq, .loggingOn, .sampleRate, .statusByte);
`default_nettype wire

// ---- testbench/logger_memory_command_unit_bench.sv ----
/* Self-checking bench of the command unit.
   Assumes the master model and a memory of addr^5Ah. */
`timescale 1ns/1ps
`default_nettype none
module logger_memory_command_unit_bench import lmc_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic minuteTick = 1'b0;
  logic clearEnableSet = 1'b0;
  logic memWrReady = 1'b0;
  logic [7:0] memRdData = 8'h00;
  logic txBit, busResetPulse, slotPulse, slotBit, memWrValid, clearEnableBit;
  logic memoryClearedFlag, missionActiveFlag, memClearReq, convStart, stampReq, loggingOn;
  logic [15:0] memRdAddr, c, r;
  logic [15:0] startDelay = 16'h0000;
  logic [7:0] sampleRate, statusByte, rate;
  logic [7:0] d[4];
  lmc_mem_wr_t memWr;
  lmc_mem_wr_t wq[$];
  int err_count, check_count, cyc, k, clrAt, convCnt;

  always #10 sys_clk = ~sys_clk;
  // memory, far side stalls and write capture
  always @(posedge sys_clk) memRdData <= memRdAddr[7:0] ^ 8'h5A;
  always @(negedge sys_clk) memWrReady <= 1'($urandom);
  always @(posedge sys_clk) if (memWrValid && memWrReady) wq.push_back(memWr);

  lmc_master u_master (.sys_clk, .txBit, .busResetPulse, .slotPulse, .slotBit);
  lmc_unit #(.MEM_LAST_ADDR(16'h007F), .CLEAR_CYC(20), .FIFO_DEPTH(16)) u_dut (
    .sys_clk, .rst, .ce(1'b1), .busResetPulse, .slotPulse, .slotBit, .txBit, .memRdAddr,
    .memRdData, .memWr, .memWrValid, .memWrReady, .clearEnableSet,
    .missionInhibitBit(1'b0), .minuteTick, .startDelay, .clearEnableBit,
    .memoryClearedFlag, .missionActiveFlag, .memClearReq, .convStart, .stampReq,
    .loggingOn, .sampleRate, .statusByte);

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // own crc over one byte, lsb first
  function automatic logic [15:0] crc8(input logic [15:0] x, input logic [7:0] v);
    for (int i = 0; i < 8; i++) x = (x >> 1) ^ ((x[0] ^ v[i]) ? CRC_POLY_REFL : 16'h0000);
    return x;
  endfunction : crc8
  task automatic wb(input logic [7:0] v);
    u_master.xfer(8, {8'h00, v}, r);
    c = crc8(c, v);
  endtask : wb
  task automatic rb(input string n, input logic [7:0] e);
    u_master.xfer(8, 16'hFFFF, r);
    chk(n, 16'(r[7:0]), 16'(e));
    c = crc8(c, e);
  endtask : rb
  task automatic rcrc();
    u_master.xfer(16, 16'hFFFF, r);
    chk("crc", r, ~c);
    c = 16'h0000;
  endtask : rcrc
  task automatic cmd(input logic [7:0] v);
    u_master.busReset();
    c = 16'h0000;
    wb(v);
  endtask : cmd
  task automatic pulseEnable();
    @(negedge sys_clk);
    clearEnableSet = 1'b1;
    @(negedge sys_clk);
    clearEnableSet = 1'b0;
  endtask : pulseEnable

  always @(posedge sys_clk) begin
    cyc++;
    // one-cycle pulses end before the command task returns
    if (memClearReq) clrAt = cyc;
    if (convStart) convCnt++;
    if (cyc == 60000) begin
      err_count++;
      test_done();
    end
  end

  initial begin
    void'($urandom(31273));
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    // write near the scratchpad end, crc answer
    cmd(CMD_WRITE_SP);
    wb(8'h1C);
    wb(8'h01);
    foreach (d[i]) begin
      d[i] = 8'($urandom);
      wb(d[i]);
    end
    rcrc();
    chk("status", 16'(statusByte), 16'h001F);
    cmd(CMD_READ_SP);
    rb("ta_lo", 8'h1C);
    rb("ta_hi", 8'h01);
    rb("es", 8'h1F);
    foreach (d[i]) rb("sp", d[i]);
    rcrc();
    rb("ones", 8'hFF);
    // copy; reset in mid-copy is ignored
    cmd(CMD_COPY_SP);
    wb(8'h1C);
    wb(8'h01);
    wb(8'h1F);
    repeat (50) @(negedge sys_clk);
    u_master.busReset();
    for (k = 0; k < 3000 && wq.size() < 4; k++) @(negedge sys_clk);
    foreach (d[i]) chk("cp_addr", wq[i].addr, 16'h011C + 16'(i));
    foreach (d[i]) chk("cp_data", 16'(wq[i].data), 16'(d[i]));
    rb("pattern", 8'hAA);
    chk("auth", 16'(statusByte), 16'h009F);
    wq.delete();
    // another command drops the clear enable
    pulseEnable();
    cmd(CMD_READ_MEM);
    wb(8'h7E);
    wb(8'h00);
    rb("mem", 8'h24);
    rb("mem", 8'h25);
    rb("end", 8'h00);
    chk("clear_enable_bit", 16'(clearEnableBit), 16'h0000);
    chk("es_kept", 16'(statusByte), 16'h009F);
    // crc read through the last page and beyond
    cmd(CMD_READ_MEM_CRC);
    wb(8'h5E);
    wb(8'h00);
    for (int a = 'h5E; a < 'hA0; a++) begin
      rb("crcmem", a < 'h80 ? 8'(a) ^ 8'h5A : 8'h00);
      if (a[4:0] == 5'h1F) rcrc();
    end
    cmd(8'h99);
    rb("unknown", 8'hFF);
    // clear memory, CLEAR_CYC shortened to 20 clocks
    pulseEnable();
    chk("clear_enable_bit", 16'(clearEnableBit), 16'h0001);
    cmd(CMD_CLEAR_MEM);
    for (k = 0; k < 100 && !memoryClearedFlag; k++) @(negedge sys_clk);
    chk("clr_time", 16'(cyc - clrAt + 1), 16'h0014);
    chk("clear_enable_bit", 16'(clearEnableBit), 16'h0000);
    chk("rate", 16'(sampleRate), 16'h0000);
    cmd(CMD_CONVERT);
    chk("conv", 16'(convCnt), 16'h0001);
    // rate write with a trailing partial byte, then mission start
    rate = 8'($urandom_range(255, 1));
    cmd(CMD_WRITE_SP);
    wb(8'h0D);
    wb(8'h02);
    wb(rate);
    u_master.xfer(3, 16'h0000, r);
    u_master.busReset();
    chk("es_pf", 16'(statusByte), 16'h002D);
    cmd(CMD_COPY_SP);
    wb(8'h0D);
    wb(8'h02);
    wb(8'h2D);
    for (k = 0; k < 3000 && !missionActiveFlag; k++) @(negedge sys_clk);
    chk("mip", 16'(missionActiveFlag), 16'h0001);
    chk("rate", 16'(sampleRate), 16'(rate));
    chk("memory_cleared_flag", 16'(memoryClearedFlag), 16'h0000);
    minuteTick = 1'b1;
    for (k = 0; k < 20 && !stampReq; k++) begin
      @(negedge sys_clk);
      minuteTick = 1'b0;
    end
    chk("stamp", 16'(stampReq), 16'h0001);
    repeat (3) @(negedge sys_clk);
    chk("log", 16'(loggingOn), 16'h0001);
    // copy into the protected page ends the mission
    wq.delete();
    cmd(CMD_WRITE_SP);
    wb(8'h00);
    wb(8'h02);
    wb(8'($urandom));
    cmd(CMD_COPY_SP);
    wb(8'h00);
    wb(8'h02);
    wb(8'h00);
    for (k = 0; k < 3000 && missionActiveFlag; k++) @(negedge sys_clk);
    repeat (300) @(negedge sys_clk);
    chk("stop", 16'(missionActiveFlag), 16'h0000);
    chk("prot_wr", 16'(wq.size()), 16'h0000);
    test_done();
  end
endmodule : logger_memory_command_unit_bench
`default_nettype wire
